// ==== hdl/core_regs_params.svh ====
`ifndef CORE_REGS_PARAMS_SVH
`define CORE_REGS_PARAMS_SVH

// Word offsets on the register bus
`define ADDR_STATUS      4'h0
`define ADDR_OPTION      4'h1
`define ADDR_INTCTL      4'h2
`define ADDR_CORE_EVENT  4'h3
`define ADDR_ALU_RESULT  4'h4
`define ADDR_PIN_CHANGE  4'h5
`define ADDR_DERIVED     4'h6

// Reset values
`define RESET_STATUS     8'h18
`define RESET_OPTION     8'hff
`define RESET_INTCTL     8'h00

// Status bit positions
`define BIT_IND_BANK     7
`define BIT_TIMEOUT      4
`define BIT_POWER_DOWN   3
`define BIT_ZERO         2
`define BIT_DIGIT_CARRY  1
`define BIT_CARRY        0

// Option bit positions
`define BIT_PULLUP_DIS   7
`define BIT_EXT_EDGE     6
`define BIT_CLOCK_SRC    5
`define BIT_SRC_EDGE     4
`define BIT_PRE_ASSIGN   3

// Interrupt control bit positions
`define BIT_GIE          7
`define BIT_PERIPHERAL_IRQ_ENABLE         6
`define BIT_TOV_EN       5
`define BIT_EXT_EN       4
`define BIT_CHG_EN       3
`define BIT_TOV_FLAG     2
`define BIT_EXT_FLAG     1
`define BIT_CHG_FLAG     0

// Core event command bits
`define EV_WDT_CLEAR     0
`define EV_SLEEP         1
`define EV_WDT_TIMEOUT   2

`endif

// ==== hdl/core_regs_pkg.sv ====
package core_regs_pkg;

  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_ADD    = 4'h1,
    OP_SUB    = 4'h2,
    OP_LOGIC  = 4'h3,
    OP_ROT_R  = 4'h4,
    OP_ROT_L  = 4'h5
  } alu_op_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [7:0]  dat;
  } wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [7:0]  dat;
  } wb_rsp_type;

  typedef struct packed {
    logic        ind_bank;
    logic [1:0]  dir_bank;
    logic        pullup_disable;
    logic        ext_edge_rising;
    logic        timer_ext_clock;
    logic        timer_falling;
    logic        prescaler_to_wdt;
    logic [8:0]  timer_divide;
    logic [8:0]  wdt_divide;
  } config_view_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_type;

endpackage : core_regs_pkg

// ==== hdl/core_status_option_intctl_regs.sv ====
// How it works
// - Indirect bank bit picks upper or lower half
// - Two bank bits pick one of four banks
// - Timeout flag high after reset, clear, sleep
// - Power-down flag set by clear, cleared by sleep
// - Zero flag follows zero result on add/sub/logic
// - Digit carry from low nibble on add/sub
// - Carry from top bit on add/sub
// - Subtract adds two's complement; borrow inverted
// - Rotates load carry with bit shifted out
// - ALU result beats software write on flags
// - Pull-up disable bit blocks all pull-ups
// - Edge bit picks external interrupt edge
// - Clock source bit picks pin or cycle clock
// - Source edge bit picks counting edge
// - Assign bit gives prescaler to watchdog or timer
// - Rate field divides by power of two
// - Timer runs 1:1 when prescaler on watchdog
// - Flags set regardless of interrupt enables
// - Global and peripheral enables gate groups
// - Timer overflow flag sticky until cleared
// - Selected pin edge sets sticky external flag
// - Any enabled pin change sets change flag
`timescale 1ns/100ps
`default_nettype none
`include "core_regs_params.svh"

module core_status_option_intctl_regs #(
  parameter int PORT_WIDTH = 6
) (
  // Clock and reset
  input  wire logic                         CLK,
  input  wire logic                         NRST,
  // Wishbone slave
  input  wire logic                         WB_CYC_I,
  input  wire logic                         WB_STB_I,
  input  wire logic                         WB_WE_I,
  input  wire logic [3:0]                   WB_ADR_I,
  input  wire logic [7:0]                   WB_DAT_I,
  input  wire logic                         WB_SEL_I,
  output logic                              WB_ACK_O,
  output logic      [7:0]                   WB_DAT_O,
  // ALU operation and operands from the core
  input  wire core_regs_pkg::alu_op_type    ALU_OP,
  input  wire logic [7:0]                   ALU_A,
  input  wire logic [7:0]                   ALU_B,
  input  wire logic                         ALU_CARRY_IN,
  // Core events and pins
  input  wire logic                         TIMER_ROLLOVER,
  input  wire logic                         EXT_IRQ_PIN,
  input  wire logic [PORT_WIDTH-1:0]        IO_PORT,
  input  wire logic                         PERIPHERAL_REQUEST,
  // Configuration view and request
  output core_regs_pkg::config_view_type    CONFIG_VIEW,
  output logic                              IRQ_REQUEST
);

  typedef struct packed {
    core_regs_pkg::bus_state_type bus;
    logic [7:0]                   rdata;
    logic [7:0]                   status;
    logic [7:0]                   option;
    logic [7:0]                   intctl;
    logic [7:0]                   alu_result;
    logic [PORT_WIDTH-1:0]        change_enable;
    logic                         irq;
    core_regs_pkg::config_view_type view;
  } state_type;

  state_type st;
  state_type next_st;

  logic                  ext_rise;
  logic                  ext_fall;
  logic [PORT_WIDTH-1:0] pin_rise;
  logic [PORT_WIDTH-1:0] pin_fall;

  edge_detect #(.WIDTH(1)) ext_edges (
    .clk   (CLK),
    .nrst  (NRST),
    .level (EXT_IRQ_PIN),
    .rise  (ext_rise),
    .fall  (ext_fall)
  );

  edge_detect #(.WIDTH(PORT_WIDTH)) pin_edges (
    .clk   (CLK),
    .nrst  (NRST),
    .level (IO_PORT),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  logic       access;
  logic       wr;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic       alu_flags;
  logic       ext_event;
  logic       chg_event;

  always_comb
  begin
    next_st   = st;
    access    = WB_CYC_I && WB_STB_I && (st.bus == core_regs_pkg::BUS_IDLE);
    wr        = access && WB_WE_I && WB_SEL_I;
    sum9      = 9'h000;
    sum5      = 5'h00;
    alu_flags = 1'b0;

    // Single-cycle answer; one idle cycle between answers
    case (st.bus)
      core_regs_pkg::BUS_IDLE:
      begin
        if (access)
        begin
          next_st.bus = core_regs_pkg::BUS_ACK;
          case (WB_ADR_I)
            `ADDR_STATUS:     next_st.rdata = st.status;
            `ADDR_OPTION:     next_st.rdata = st.option;
            `ADDR_INTCTL:     next_st.rdata = st.intctl;
            `ADDR_ALU_RESULT: next_st.rdata = st.alu_result;
            `ADDR_PIN_CHANGE: next_st.rdata = 8'(st.change_enable);
            default:          next_st.rdata = 8'h00;
          endcase
        end
      end
      core_regs_pkg::BUS_ACK:
        next_st.bus = core_regs_pkg::BUS_IDLE;
      default:
        next_st.bus = core_regs_pkg::BUS_IDLE;
    endcase

    // Software writes; status keeps timeout and power-down read-only
    if (wr)
    begin
      case (WB_ADR_I)
        `ADDR_STATUS:
        begin
          next_st.status[7:5] = WB_DAT_I[7:5];
          next_st.status[2:0] = WB_DAT_I[2:0];
        end
        `ADDR_OPTION:     next_st.option = WB_DAT_I;
        `ADDR_INTCTL:     next_st.intctl = WB_DAT_I;
        `ADDR_PIN_CHANGE: next_st.change_enable = WB_DAT_I[PORT_WIDTH-1:0];
        `ADDR_CORE_EVENT:
        begin
          if (WB_DAT_I[`EV_WDT_CLEAR])
          begin
            next_st.status[`BIT_TIMEOUT]    = 1'b1;
            next_st.status[`BIT_POWER_DOWN] = 1'b1;
          end
          else if (WB_DAT_I[`EV_SLEEP])
          begin
            next_st.status[`BIT_TIMEOUT]    = 1'b1;
            next_st.status[`BIT_POWER_DOWN] = 1'b0;
          end
          if (WB_DAT_I[`EV_WDT_TIMEOUT])
            next_st.status[`BIT_TIMEOUT] = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // Flag updates come after the write so hardware wins
    case (ALU_OP)
      core_regs_pkg::OP_ADD, core_regs_pkg::OP_SUB:
      begin
        // Plus one added at full width, so nibble and top carries survive
        if (ALU_OP == core_regs_pkg::OP_SUB)
        begin
          sum9 = {1'b0, ALU_A} + {1'b0, ~ALU_B} + 9'h001;
          sum5 = {1'b0, ALU_A[3:0]} + {1'b0, ~ALU_B[3:0]} + 5'h01;
        end
        else
        begin
          sum9 = {1'b0, ALU_A} + {1'b0, ALU_B};
          sum5 = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]};
        end
        next_st.alu_result = sum9[7:0];
        next_st.status[`BIT_CARRY]       = sum9[8];
        next_st.status[`BIT_DIGIT_CARRY] = sum5[4];
        alu_flags = 1'b1;
      end
      core_regs_pkg::OP_LOGIC:
      begin
        next_st.alu_result = ALU_A;
        alu_flags = 1'b1;
      end
      core_regs_pkg::OP_ROT_R:
      begin
        next_st.alu_result         = {ALU_CARRY_IN, ALU_A[7:1]};
        next_st.status[`BIT_CARRY] = ALU_A[0];
      end
      core_regs_pkg::OP_ROT_L:
      begin
        next_st.alu_result         = {ALU_A[6:0], ALU_CARRY_IN};
        next_st.status[`BIT_CARRY] = ALU_A[7];
      end
      default:
      begin
      end
    endcase
    if (alu_flags)
      next_st.status[`BIT_ZERO] = (next_st.alu_result == 8'h00);

    // Set beats software clear
    ext_event = st.option[`BIT_EXT_EDGE] ? ext_rise : ext_fall;
    chg_event = |((pin_rise | pin_fall) & st.change_enable);
    if (TIMER_ROLLOVER)
      next_st.intctl[`BIT_TOV_FLAG] = 1'b1;
    if (ext_event)
      next_st.intctl[`BIT_EXT_FLAG] = 1'b1;
    if (chg_event)
      next_st.intctl[`BIT_CHG_FLAG] = 1'b1;

    // Request drawn from the registered flags
    next_st.irq = st.intctl[`BIT_GIE] && (
      (st.intctl[`BIT_TOV_EN] && st.intctl[`BIT_TOV_FLAG]) ||
      (st.intctl[`BIT_EXT_EN] && st.intctl[`BIT_EXT_FLAG]) ||
      (st.intctl[`BIT_CHG_EN] && st.intctl[`BIT_CHG_FLAG]) ||
      (st.intctl[`BIT_PERIPHERAL_IRQ_ENABLE] && PERIPHERAL_REQUEST));

    // Decoded controls for the timer, watchdog and port
    next_st.view.ind_bank         = st.status[`BIT_IND_BANK];
    next_st.view.dir_bank         = st.status[6:5];
    next_st.view.pullup_disable   = st.option[`BIT_PULLUP_DIS];
    next_st.view.ext_edge_rising  = st.option[`BIT_EXT_EDGE];
    next_st.view.timer_ext_clock  = st.option[`BIT_CLOCK_SRC];
    next_st.view.timer_falling    = st.option[`BIT_SRC_EDGE];
    next_st.view.prescaler_to_wdt = st.option[`BIT_PRE_ASSIGN];
    if (st.option[`BIT_PRE_ASSIGN])
    begin
      next_st.view.timer_divide = 9'h001;
      next_st.view.wdt_divide   = 9'h001 << st.option[2:0];
    end
    else
    begin
      next_st.view.timer_divide = 9'h002 << st.option[2:0];
      next_st.view.wdt_divide   = 9'h001;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st                       <= '0;
      st.bus                   <= core_regs_pkg::BUS_IDLE;
      st.status                <= `RESET_STATUS;
      st.option                <= `RESET_OPTION;
      st.intctl                <= `RESET_INTCTL;
      st.view.ind_bank         <= 1'b0;
      st.view.pullup_disable   <= 1'b1;
      st.view.ext_edge_rising  <= 1'b1;
      st.view.timer_ext_clock  <= 1'b1;
      st.view.timer_falling    <= 1'b1;
      st.view.prescaler_to_wdt <= 1'b1;
      st.view.timer_divide     <= 9'h001;
      st.view.wdt_divide       <= 9'h080;
    end
    else
      st <= next_st;
  end

  assign WB_ACK_O    = (st.bus == core_regs_pkg::BUS_ACK);
  assign WB_DAT_O    = st.rdata;
  assign CONFIG_VIEW = st.view;
  assign IRQ_REQUEST = st.irq;

endmodule : core_status_option_intctl_regs

`default_nettype wire

// ==== hdl/edge_detect.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "core_regs_params.svh"

// Registered edge detector on a synchronous input
module edge_detect #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Sampled level and edges
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] last;
  logic             primed;

  // No edge until one real sample is held, so a pin idling high gives no false edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      last   <= '0;
      primed <= 1'b0;
    end
    else
    begin
      last   <= level;
      primed <= 1'b1;
    end
  end

  assign rise = level & ~last & {WIDTH{primed}};
  assign fall = ~level & last & {WIDTH{primed}};

endmodule : edge_detect

`default_nettype wire

// ==== verification/core_regs_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module core_regs_monitor (
  // Clock and reset
  input wire logic                           CLK,
  input wire logic                           NRST,
  // Register bus
  input wire logic                           WB_CYC_I,
  input wire logic                           WB_STB_I,
  input wire logic                           WB_WE_I,
  input wire logic [3:0]                     WB_ADR_I,
  input wire logic [7:0]                     WB_DAT_I,
  input wire logic                           WB_SEL_I,
  input wire logic                           WB_ACK_O,
  input wire logic [7:0]                     WB_DAT_O,
  // Requests and view
  input wire logic                           PERIPHERAL_REQUEST,
  input wire core_regs_pkg::config_view_type CONFIG_VIEW,
  input wire logic                           IRQ_REQUEST
);
  logic       take;
  logic       wr;
  logic [7:0] opt;
  logic [2:0] bank;
  logic [1:0] en;

  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr   = take && WB_WE_I && WB_SEL_I;

  // Mirror of fields only software changes
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      opt  <= 8'hff;
      bank <= 3'h0;
      en   <= 2'h0;
    end
    else if (wr)
    begin
      case (WB_ADR_I)
        4'h0: bank <= WB_DAT_I[7:5];
        4'h1: opt <= WB_DAT_I;
        4'h2: en <= WB_DAT_I[7:6];
        default: ;
      endcase
    end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_resp; take |=> WB_ACK_O; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  property p_unmap; take && !WB_WE_I && WB_ADR_I > 4'h5 |=> WB_DAT_O == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_bank; {CONFIG_VIEW.ind_bank, CONFIG_VIEW.dir_bank} == $past(bank); endproperty
  a_bank: assert property (p_bank) else $error("bank view wrong");
  property p_view;
    {CONFIG_VIEW.pullup_disable, CONFIG_VIEW.ext_edge_rising, CONFIG_VIEW.timer_ext_clock,
     CONFIG_VIEW.timer_falling, CONFIG_VIEW.prescaler_to_wdt} == $past(opt[7:3]);
  endproperty
  a_view: assert property (p_view) else $error("option view wrong");
  property p_tdiv; !$past(opt[3]) |-> CONFIG_VIEW.timer_divide == 9'h002 << $past(opt[2:0]);
  endproperty
  a_tdiv: assert property (p_tdiv) else $error("timer divide wrong");
  property p_wdiv; $past(opt[3]) |-> CONFIG_VIEW.wdt_divide == 9'h001 << $past(opt[2:0]);
  endproperty
  a_wdiv: assert property (p_wdiv) else $error("watchdog divide wrong");
  property p_one; $past(opt[3]) |-> CONFIG_VIEW.timer_divide == 9'h001; endproperty
  a_one: assert property (p_one) else $error("timer not unscaled");
  property p_irq_off; !en[1] |=> !IRQ_REQUEST; endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while disabled");
  property p_irq_per; en == 2'b11 && PERIPHERAL_REQUEST |-> ##[1:2] IRQ_REQUEST; endproperty
  a_irq_per: assert property (p_irq_per) else $error("peripheral request lost");

  c_irq: cover property (IRQ_REQUEST);
  c_write: cover property (wr);
  c_assign: cover property (CONFIG_VIEW.prescaler_to_wdt ##1 !CONFIG_VIEW.prescaler_to_wdt);
endmodule : core_regs_monitor

bind core_status_option_intctl_regs core_regs_monitor core_regs_monitor_i (
  .CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_ACK_O(WB_ACK_O),
  .WB_DAT_O(WB_DAT_O), .PERIPHERAL_REQUEST(PERIPHERAL_REQUEST),
  .CONFIG_VIEW(CONFIG_VIEW), .IRQ_REQUEST(IRQ_REQUEST)
);
`default_nettype wire

// ==== verification/core_status_option_intctl_regs_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module core_status_option_intctl_regs_bench;
  logic                          CLK = 1'b0;
  logic                          NRST = 1'b0;
  logic                          WB_CYC_I = 1'b0;
  logic                          WB_STB_I = 1'b0;
  logic                          WB_WE_I = 1'b0;
  logic [3:0]                    WB_ADR_I = 4'h0;
  logic [7:0]                    WB_DAT_I = 8'h00;
  logic                          WB_SEL_I = 1'b0;
  logic                          WB_ACK_O;
  logic [7:0]                    WB_DAT_O;
  core_regs_pkg::alu_op_type     ALU_OP = core_regs_pkg::OP_NONE;
  logic [7:0]                    ALU_A = 8'h00;
  logic [7:0]                    ALU_B = 8'h00;
  logic                          ALU_CARRY_IN = 1'b0;
  logic                          TIMER_ROLLOVER = 1'b0;
  logic                          EXT_IRQ_PIN = 1'b1;
  logic [5:0]                    IO_PORT = 6'h00;
  logic                          PERIPHERAL_REQUEST = 1'b0;
  core_regs_pkg::config_view_type CONFIG_VIEW;
  logic                          IRQ_REQUEST;
  logic [7:0]                    exp_q[$];
  logic [7:0]                    st = 8'h18;
  logic [8:0]                    s;
  logic [4:0]                    h;
  int                            err_total = 0;
  int                            cmp_count = 0;
  int                            cycles = 0;
  integer                        seed = 32'hc5b36aa1;

  core_status_option_intctl_regs core_status_option_intctl_regs_i (
    .CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_ACK_O(WB_ACK_O),
    .WB_DAT_O(WB_DAT_O), .ALU_OP(ALU_OP), .ALU_A(ALU_A), .ALU_B(ALU_B),
    .ALU_CARRY_IN(ALU_CARRY_IN), .TIMER_ROLLOVER(TIMER_ROLLOVER), .EXT_IRQ_PIN(EXT_IRQ_PIN),
    .IO_PORT(IO_PORT), .PERIPHERAL_REQUEST(PERIPHERAL_REQUEST), .CONFIG_VIEW(CONFIG_VIEW),
    .IRQ_REQUEST(IRQ_REQUEST)
  );

  always #5 CLK = ~CLK;

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  function automatic logic [7:0] r8();
    return 8'($random(seed));
  endfunction : r8

  // For reads the data argument is the expected value
  task automatic wb(logic we, logic [3:0] adr, logic [7:0] dat, logic sel = 1'b1);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= dat;
    WB_SEL_I <= sel;
    if (!we)
      exp_q.push_back(dat);
    do
      @(posedge CLK);
    while (WB_ACK_O !== 1'b1);
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask : wb

  task automatic alu(core_regs_pkg::alu_op_type op, logic [7:0] x, logic [7:0] y);
    ALU_OP       <= op;
    ALU_A        <= x;
    ALU_B        <= y;
    ALU_CARRY_IN <= 1'($random(seed));
    s = {1'b0, x} + ((op == core_regs_pkg::OP_SUB) ? {1'b0, ~y} + 9'h001 : {1'b0, y});
    h = {1'b0, x[3:0]} + ((op == core_regs_pkg::OP_SUB) ? {1'b0, ~y[3:0]} + 5'h01 : {1'b0, y[3:0]});
    case (op)
      core_regs_pkg::OP_ADD, core_regs_pkg::OP_SUB: st[2:0] = {s[7:0] == 8'h00, h[4], s[8]};
      core_regs_pkg::OP_LOGIC: st[2] = (x == 8'h00);
      core_regs_pkg::OP_ROT_R: st[0] = x[0];
      default: st[0] = x[7];
    endcase
    @(posedge CLK);
    ALU_OP <= core_regs_pkg::OP_NONE;
  endtask : alu

  task automatic irq_is(logic e);
    @(negedge CLK);
    check("irq request", {7'h00, IRQ_REQUEST}, {7'h00, e});
    @(posedge CLK);
  endtask : irq_is

  always @(posedge CLK)
    if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0)
      check("read data", WB_DAT_O, exp_q.pop_front());

  // Ceiling is about eighteen times the expected run
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    logic [7:0] ev[5] = '{8'h02, 8'h04, 8'h01, 8'h04, 8'h03};
    logic [1:0] tp[5] = '{2'b10, 2'b00, 2'b11, 2'b01, 2'b11};
    logic [7:0] d;
    repeat (10) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    wb(0, 4'h0, 8'h18);
    wb(0, 4'h1, 8'hff);
    wb(0, 4'h2, 8'h00);
    wb(0, 4'h3, 8'h00);
    wb(0, 4'h6, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 20; i++)
    begin
      alu(core_regs_pkg::alu_op_type'(4'(1 + i % 5)), r8(), r8());
      wb(0, 4'h0, st);
    end
    alu(core_regs_pkg::OP_SUB, 8'h5a, 8'h5a);
    wb(0, 4'h0, st);
    wb(0, 4'h4, 8'h00);
    alu(core_regs_pkg::OP_SUB, 8'h33, 8'h10);
    wb(0, 4'h0, st);
    wb(0, 4'h4, 8'h23);
    alu(core_regs_pkg::OP_ADD, 8'h88, 8'h78);
    wb(0, 4'h0, st);
    $display("flag test done");
    ALU_OP <= core_regs_pkg::OP_ADD;
    ALU_A  <= 8'h00;
    ALU_B  <= 8'h00;
    wb(1, 4'h0, 8'hff);
    ALU_OP <= core_regs_pkg::OP_NONE;
    wb(1, 4'h0, 8'h00, 1'b0);
    wb(0, 4'h0, 8'hfc);
    wb(1, 4'h0, 8'h00);
    st = 8'h18;
    for (int i = 0; i < 5; i++)
    begin
      wb(1, 4'h3, ev[i]);
      st[4:3] = tp[i];
      wb(0, 4'h0, st);
    end
    $display("status test done");
    for (int i = 0; i < 8; i++)
    begin
      d      = r8();
      d[2:0] = 3'(i);
      wb(1, 4'h1, d);
      wb(0, 4'h1, d);
    end
    $display("option test done");
    wb(1, 4'h1, 8'h00);
    TIMER_ROLLOVER <= 1'b1;
    @(posedge CLK);
    TIMER_ROLLOVER <= 1'b0;
    wb(0, 4'h2, 8'h04);
    EXT_IRQ_PIN <= 1'b0;
    repeat (3) @(posedge CLK);
    wb(0, 4'h2, 8'h06);
    wb(1, 4'h2, 8'h00);
    wb(1, 4'h1, 8'h40);
    EXT_IRQ_PIN <= 1'b1;
    repeat (3) @(posedge CLK);
    wb(0, 4'h2, 8'h02);
    wb(1, 4'h2, 8'h00);
    EXT_IRQ_PIN <= 1'b0;
    wb(1, 4'h5, 8'h01);
    wb(0, 4'h5, 8'h01);
    IO_PORT <= 6'h02;
    repeat (3) @(posedge CLK);
    wb(0, 4'h2, 8'h00);
    IO_PORT <= 6'h03;
    repeat (3) @(posedge CLK);
    wb(0, 4'h2, 8'h01);
    wb(1, 4'h2, 8'h89);
    irq_is(1'b1);
    wb(1, 4'h2, 8'h09);
    irq_is(1'b0);
    PERIPHERAL_REQUEST <= 1'b1;
    wb(1, 4'h2, 8'hc0);
    irq_is(1'b1);
    wb(1, 4'h2, 8'h80);
    irq_is(1'b0);
    $display("interrupt test done");
    report_and_stop();
  end
endmodule : core_status_option_intctl_regs_bench
`default_nettype wire
